// >>> design/load_driver_fault_diagnostics.sv
// four-channel low-side driver fault diagnostics with apb register access
`timescale 1ns/100ps
`default_nettype none

// How it works
// [RL1] gate-on checks run only with gate high, gate-off checks only with gate low
// [RL2] detected faults latch in fault register; unmasked ones pull fault pin low
// [RL3] reset sets the reset-seen flag; a fault read clears it until next reset
// [RL4] enable-low flag set while enable low; cleared by a read after enable high
// [RL5] timebase divides clock by 128, 192, 192 or 256 per two-bit select
// [RL6] filter and tested timers expire on the 9th timebase tick, 8 to 9 tick periods after start
// [RL7] fault bit never reads one while its tested bit reads zero
// [RL8] in on/off mode gate-on open-load detection is off, bit held zero
// [RL9] gate rise clears filters, starts tested timer; expiry sets battery-short tested
// [RL10] battery-short filter counts while raw high; raw low clears it at once
// [RL11] filtered battery short with tested bit forces gate off until retry expiry
// [RL12] fault read clears battery-short fault, its tested bit and tested timer
// [RL13] battery short works in both modes; off-state filters zero while gate high
// [RL14] constant-current mode: 64 pwm periods high sets gate-on open load, repeatedly
// [RL15] gate fall clears filters, starts tested timer; expiry sets off-state tested bit
// [RL16] open-load filter counts while raw high; raw low clears it at once
// [RL17] ground-short filter counts while raw high; raw low clears it at once
// [RL18] filtered ground short after tested expiry sets ground fault, open load untouched
// [RL19] no ground short with filtered open load sets gate-off open-load fault
// [RL20] fault read clears off tested, ground fault, off open-load fault and timers
// [RL21] software commands zero current before judging gate-off fault bits
// [RL22] under reset all channels off and all registers at defaults
// [RL23] each channel has its own timers and bits, sharing one timebase
module load_driver_fault_diagnostics
   import load_diag_pkg::*;
#(
   parameter int OL_ON_COUNT = OL_ON_PERIODS
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // device pins and channel inputs
   input  wire logic              enable_in,
   input  wire logic [NUM_CH-1:0] gate_cmd,
   input  wire logic [NUM_CH-1:0] pwm_period_pulse,
   input  wire logic [NUM_CH-1:0] retry_expire,
   input  wire logic [NUM_CH-1:0] bat_short_raw,
   input  wire logic [NUM_CH-1:0] gnd_short_raw,
   input  wire logic [NUM_CH-1:0] open_load_raw,
   // outputs
   output logic [NUM_CH-1:0]      gate_drive_out,
   output logic                   fault_pin_o,
   output logic                   fault_pin_oe
);

   typedef struct packed {
      logic [1:0]              tb_sel;
      logic [NUM_CH-1:0]       onoff_mode;
      logic [FAULT_W-1:0]      mask;
      logic [7:0]              pre_cnt;
      logic                    tick;
      logic [FAULT_W-1:0]      fault_vec;
      logic [FAULT_W-1:0]      snap;
      logic [NUM_CH-1:0]       gate_prev;
      logic [NUM_CH-1:0]       gate_out;
      logic [NUM_CH-1:0]       forced_off;
      logic [NUM_CH-1:0][3:0]  tt_cnt;
      logic [NUM_CH-1:0][3:0]  sb_cnt;
      logic [NUM_CH-1:0][3:0]  sg_cnt;
      logic [NUM_CH-1:0][3:0]  ol_cnt;
      logic [NUM_CH-1:0][6:0]  olon_cnt;
      logic [31:0]             rdata;
      logic                    slverr;
      logic                    fault_oe;
   } state_t;

   localparam logic [6:0] OLON_TOP = 7'(OL_ON_COUNT - 1);

   state_t state_reg;
   state_t state_next;

   // status view of filtered signals, read only
   logic [NUM_CH-1:0] bat_short_filtered;
   logic [NUM_CH-1:0] gnd_short_filtered;
   logic [NUM_CH-1:0] open_load_off_filtered;

   always_comb begin
      logic             rd_acc;
      logic             wr_acc;
      logic             fault_rd;
      logic             mapped;
      logic [7:0]       pre_top;
      logic [FAULT_W-1:0] set_vec;
      logic [FAULT_W-1:0] clr_vec;
      logic             gate;
      logic             edge_any;
      logic             tt_exp;
      logic             sb_hit;
      int               b;
      state_next = state_reg;
      rd_acc     = psel & penable & ~pwrite;
      wr_acc     = psel & penable & pwrite;
      fault_rd   = rd_acc && (paddr == FAULT_OFS);
      mapped     = (paddr == CTRL_OFS) || (paddr == MASK_OFS) ||
                   (paddr == FAULT_OFS) || (paddr == STATUS_OFS);
      set_vec    = '0;
      clr_vec    = fault_rd ? state_reg.snap : '0;
      gate       = 1'b0;
      edge_any   = 1'b0;
      tt_exp     = 1'b0;
      sb_hit     = 1'b0;
      b          = 0;
      pre_top    = PRE_TOP_128;
      bat_short_filtered     = '0;
      gnd_short_filtered     = '0;
      open_load_off_filtered = '0;

      // shared diagnostic timebase
      case (state_reg.tb_sel)  // [RL5]
         2'b00:   pre_top = PRE_TOP_128;
         2'b01:   pre_top = PRE_TOP_192;
         2'b10:   pre_top = PRE_TOP_192;
         default: pre_top = PRE_TOP_256;
      endcase
      state_next.tick = 1'b0;
      if (state_reg.pre_cnt >= pre_top) begin
         state_next.pre_cnt = '0;
         state_next.tick    = 1'b1;
      end else begin
         state_next.pre_cnt = state_reg.pre_cnt + 8'h01;
      end

      // per channel diagnostics, all off one timebase
      for (int ch = 0; ch < NUM_CH; ch++) begin  // [RL23]
         b        = ch * CH_FLD_W;
         gate     = state_reg.gate_out[ch];
         edge_any = state_reg.gate_out[ch] ^ state_reg.gate_prev[ch];
         tt_exp   = (state_reg.tt_cnt[ch] == FILT_TICKS);
         state_next.gate_prev[ch] = gate;

         // tested timer: restarted on either gate edge and on every fault read
         if (edge_any || fault_rd) begin  // [RL9] [RL12] [RL15] [RL20]
            state_next.tt_cnt[ch] = '0;
         end else if (state_reg.tick && !tt_exp) begin  // [RL6]
            state_next.tt_cnt[ch] = state_reg.tt_cnt[ch] + 4'h1;
         end

         // battery short filter, on-state only
         if (!bat_short_raw[ch] || !gate || edge_any) begin  // [RL10] [RL1]
            state_next.sb_cnt[ch] = '0;
         end else if (state_reg.tick && state_reg.sb_cnt[ch] != FILT_TICKS) begin
            state_next.sb_cnt[ch] = state_reg.sb_cnt[ch] + 4'h1;
         end
         bat_short_filtered[ch] = gate && (state_reg.sb_cnt[ch] == FILT_TICKS);

         // ground short filter, off-state only
         if (!gnd_short_raw[ch] || gate || edge_any || fault_rd) begin  // [RL17] [RL13]
            state_next.sg_cnt[ch] = '0;
         end else if (state_reg.tick && state_reg.sg_cnt[ch] != FILT_TICKS) begin
            state_next.sg_cnt[ch] = state_reg.sg_cnt[ch] + 4'h1;
         end
         gnd_short_filtered[ch] = !gate && (state_reg.sg_cnt[ch] == FILT_TICKS);  // [RL13]

         // open load filter, off-state only
         if (!open_load_raw[ch] || gate || edge_any || fault_rd) begin  // [RL16] [RL13]
            state_next.ol_cnt[ch] = '0;
         end else if (state_reg.tick && state_reg.ol_cnt[ch] != FILT_TICKS) begin
            state_next.ol_cnt[ch] = state_reg.ol_cnt[ch] + 4'h1;
         end
         open_load_off_filtered[ch] = !gate && (state_reg.ol_cnt[ch] == FILT_TICKS);

         if (gate && !edge_any) begin  // [RL1]
            // on-state: tested bit first, fault only once tested is already set
            // a read restarts the timer, so expiry must not re-set the bit it clears
            if (tt_exp && !fault_rd) begin
               set_vec[b + FLD_BAT_SHORT_T] = 1'b1;  // [RL9] [RL12]
            end
            sb_hit = bat_short_filtered[ch] && state_reg.fault_vec[b + FLD_BAT_SHORT_T];  // [RL7]
            if (sb_hit) begin
               set_vec[b + FLD_BAT_SHORT_F] = 1'b1;  // [RL11] [RL13]
               set_vec[b + FLD_BAT_SHORT_T] = 1'b1;  // [RL7]
            end
         end else begin
            sb_hit = 1'b0;
         end

         if (!gate && !edge_any && tt_exp && !fault_rd) begin  // [RL1] [RL20]
            // off-state results only after the tested timer, keeps fault-without-tested impossible
            set_vec[b + FLD_OFF_TESTED] = 1'b1;  // [RL15] [RL7]
            if (gnd_short_filtered[ch]) begin
               set_vec[b + FLD_GND_SHORT_F] = 1'b1;  // [RL18]
            end else if (open_load_off_filtered[ch]) begin
               set_vec[b + FLD_OPEN_LOAD_OFF_FAULT] = 1'b1;  // [RL19]
            end
         end

         // gate-on open load counts whole pwm periods in constant-current mode
         if (!gate || state_reg.onoff_mode[ch]) begin  // [RL8]
            state_next.olon_cnt[ch] = '0;
         end else if (pwm_period_pulse[ch]) begin
            if (state_reg.olon_cnt[ch] == OLON_TOP) begin  // [RL14]
               state_next.olon_cnt[ch] = '0;
               set_vec[b + FLD_OPEN_LOAD_ON_FAULT] = 1'b1;
            end else begin
               state_next.olon_cnt[ch] = state_reg.olon_cnt[ch] + 7'h01;
            end
         end

         // shutdown latch: a new short wins over a retry expiry in the same cycle
         if (sb_hit) begin
            state_next.forced_off[ch] = 1'b1;  // [RL11]
         end else if (retry_expire[ch]) begin
            state_next.forced_off[ch] = 1'b0;
         end
         // default enable behaviour: enable low turns the channel off
         state_next.gate_out[ch] = gate_cmd[ch] & enable_in & ~state_next.forced_off[ch];
      end

      // global flags
      if (!enable_in) begin
         set_vec[FLD_ENABLE_LOW] = 1'b1;  // [RL4]
      end

      // a fault bit set after the snapshot keeps its tested bit through the read
      for (int ch = 0; ch < NUM_CH; ch++) begin  // [RL7]
         if (state_reg.fault_vec[ch * CH_FLD_W + FLD_BAT_SHORT_F] &&
             !clr_vec[ch * CH_FLD_W + FLD_BAT_SHORT_F]) begin
            clr_vec[ch * CH_FLD_W + FLD_BAT_SHORT_T] = 1'b0;
         end
         if ((state_reg.fault_vec[ch * CH_FLD_W + FLD_GND_SHORT_F] &&
              !clr_vec[ch * CH_FLD_W + FLD_GND_SHORT_F]) ||
             (state_reg.fault_vec[ch * CH_FLD_W + FLD_OPEN_LOAD_OFF_FAULT] &&
              !clr_vec[ch * CH_FLD_W + FLD_OPEN_LOAD_OFF_FAULT])) begin
            clr_vec[ch * CH_FLD_W + FLD_OFF_TESTED] = 1'b0;
         end
      end

      // only bits that software actually saw are cleared; set wins over clear
      state_next.fault_vec = (state_reg.fault_vec & ~clr_vec) | set_vec;  // [RL2] [RL3] [RL12] [RL20]
      for (int ch = 0; ch < NUM_CH; ch++) begin
         if (state_reg.onoff_mode[ch]) begin
            state_next.fault_vec[ch * CH_FLD_W + FLD_OPEN_LOAD_ON_FAULT] = 1'b0;  // [RL8]
         end
      end
      state_next.fault_oe = |(state_next.fault_vec & FAULT_BITS & ~state_reg.mask);  // [RL2]

      // apb: read data and snapshot taken in the setup cycle
      if (psel && !penable) begin
         state_next.slverr = !mapped;
         state_next.snap   = '0;
         case (paddr)
            CTRL_OFS: begin
               state_next.rdata = {24'h00_0000, state_reg.onoff_mode, 2'b00, state_reg.tb_sel};
            end
            MASK_OFS: begin
               state_next.rdata = {6'h00, state_reg.mask};
            end
            FAULT_OFS: begin
               state_next.rdata = {6'h00, state_reg.fault_vec};
               state_next.snap  = pwrite ? '0 : state_reg.fault_vec;
            end
            STATUS_OFS: begin
               state_next.rdata = {12'h000, state_reg.forced_off, open_load_off_filtered,
                                   gnd_short_filtered, bat_short_filtered, state_reg.gate_out};
            end
            default: begin
               state_next.rdata = '0;
            end
         endcase
      end
      if (wr_acc) begin
         case (paddr)
            CTRL_OFS: begin
               state_next.tb_sel     = {pwdata[CTRL_SEL_HI], pwdata[CTRL_SEL_LO]};
               state_next.onoff_mode = pwdata[CTRL_ONOFF_LO +: NUM_CH];
            end
            MASK_OFS: begin
               state_next.mask = pwdata[FAULT_W-1:0];
            end
            default: begin
               state_next.mask = state_reg.mask;
            end
         endcase
      end
   end

   // register map
   //   ctrl   : [1:0] timebase select, [7:4] on/off mode per channel
   //   mask   : one bit per fault register bit, 1 keeps it off the pin
   //   fault  : six bits per channel, then reset-seen and enable-low
   //   status : gate, filtered signals and shutdown latch, read only
   //
   // per-channel fault field
   //   +0 battery short fault
   //   +1 battery short tested
   //   +2 ground short fault
   //   +3 off-state open load fault
   //   +4 off-state tested
   //   +5 on-state open load fault
   //
   // apb timing
   //   no wait states, pready tied high
   //   read data and clear snapshot captured in the setup cycle
   //   the access cycle clears only bits present in the snapshot
   //   a bit that sets between setup and access survives the read
   //   writes to fault and status are ignored without error
   //
   // timebase and timers
   //   one prescaler shared by all channels, terminal count per select
   //   timers count ticks, so expiry lands 8 to 9 tick periods after start
   //   a timer start is not aligned to the tick, hence the spread
   //   changing the select in mid-test stretches or shortens that test
   //
   // gate edges
   //   checks are skipped in the cycle of a gate edge
   //   the edge cycle restarts the tested timer and clears the filters
   //   costs one cycle of detection, avoids judging the wrong state
   //
   // shutdown
   //   a short latches the channel off in the same edge it is seen
   //   only a retry pulse releases it; the command alone cannot
   //   a new short wins over a retry pulse in the same cycle
   //
   // fault pin
   //   tested bits never drive the pin, only fault and global flags
   //   the pin follows the latched bits, so it stays low until read
   //   open-drain: data tied low, enable high while pulling down
   //
   // limitations
   //   enable low always turns channels off; no freeze behaviour
   //   on-state open load counts pwm pulses only while gate is high
   //   a gate drop restarts that count from zero

   // reset leaves reset-seen set and every channel off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin  // [RL22] [RL3]
         state_reg            <= '0;
         state_reg.tb_sel     <= TB_SEL_RST;
         state_reg.onoff_mode <= ONOFF_RST;
         state_reg.mask       <= MASK_RST;
         state_reg.fault_vec  <= FAULT_RST;
         state_reg.fault_oe   <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata         = state_reg.rdata;
   assign pready         = 1'b1;
   assign pslverr        = state_reg.slverr & psel & penable;
   assign gate_drive_out = state_reg.gate_out;
   assign fault_pin_o    = 1'b0;
   assign fault_pin_oe   = state_reg.fault_oe;

endmodule

`default_nettype wire

// >>> include/load_diag_pkg.sv
// constants, register map and field layout of the load fault diagnostics block
package load_diag_pkg;

   // channel count and per-channel field layout in the fault register
   localparam int NUM_CH           = 4;
   localparam int CH_FLD_W         = 6;
   localparam int FLD_BAT_SHORT_F  = 0;
   localparam int FLD_BAT_SHORT_T  = 1;
   localparam int FLD_GND_SHORT_F  = 2;
   localparam int FLD_OPEN_LOAD_OFF_FAULT     = 3;
   localparam int FLD_OFF_TESTED   = 4;
   localparam int FLD_OPEN_LOAD_ON_FAULT      = 5;
   localparam int FLD_RESET_SEEN   = 24;
   localparam int FLD_ENABLE_LOW   = 25;
   localparam int FAULT_W          = 26;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] MASK_OFS   = 8'h04;
   localparam logic [7:0] FAULT_OFS  = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;

   // control register fields
   localparam int CTRL_SEL_LO   = 0;
   localparam int CTRL_SEL_HI   = 1;
   localparam int CTRL_ONOFF_LO = 4;

   // reset values
   localparam logic [1:0]  TB_SEL_RST  = 2'h0;
   localparam logic [3:0]  ONOFF_RST   = 4'h0;
   localparam logic [25:0] MASK_RST    = 26'h000_0000;
   localparam logic [25:0] FAULT_RST   = 26'h100_0000;
   // bits that are faults (tested bits never drive the pin)
   localparam logic [25:0] FAULT_BITS  = 26'h3B6_DB6D;

   // prescaler terminal counts: divide by 128, 192, 256
   localparam logic [7:0] PRE_TOP_128 = 8'h7F;
   localparam logic [7:0] PRE_TOP_192 = 8'hBF;
   localparam logic [7:0] PRE_TOP_256 = 8'hFF;

   // filter / tested timers expire on the 9th timebase tick (8..9 periods)
   localparam logic [3:0] FILT_TICKS = 4'h9;
   // pwm periods of continuous on-time before gate-on open load is flagged
   localparam int OL_ON_PERIODS = 64;

endpackage

// >>> bench/diag_assertions.sv
// port-level checks for the load fault diagnostics block
`timescale 1ns/100ps
`default_nettype none
module diag_assertions
   import load_diag_pkg::*;
(
   // clock, reset and apb
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // channels
   input wire logic              enable_in,
   input wire logic [NUM_CH-1:0] gate_cmd,
   input wire logic [NUM_CH-1:0] retry_expire,
   input wire logic [NUM_CH-1:0] gate_drive_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   function automatic logic pairs_ok(input logic [31:0] d);
      pairs_ok = d[31:26] == 6'h00;
      for (int c = 0; c < NUM_CH; c++) begin
         if (d[6*c] && !d[6*c+1])
            pairs_ok = 1'b0;
         if ((d[6*c+2] || d[6*c+3]) && !d[6*c+4])
            pairs_ok = 1'b0;
      end
   endfunction

   pready_high_a: assert property (pready)
      else $error("pready low");
   err_unmapped_a: assert property (psel && !penable && paddr > 8'h0F ##1 psel && penable |-> pslverr)
      else $error("unmapped access without error");
   err_mapped_a: assert property (psel && !penable && paddr < 8'h10 && paddr[1:0] == 2'b00 ##1 penable |-> !pslverr)
      else $error("error on mapped access");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   gate_cmd_a: assert property ((gate_drive_out & ~$past(gate_cmd)) == 4'h0)
      else $error("gate high without command");
   gate_en_a: assert property (!$past(enable_in) |-> gate_drive_out == 4'h0)
      else $error("gate high while disabled");
   bits_pair_a: assert property (psel && !penable && !pwrite && paddr == FAULT_OFS |=> pairs_ok(prdata))
      else $error("fault bit without tested bit");
   // a shutdown fall holds the gate low for the next four cycles
   shut_hold_a: assert property ($fell(gate_drive_out[0]) && $past(gate_cmd[0]) && $past(enable_in)
      |=> !gate_drive_out[0] [*4])
      else $error("gate back on after shutdown");

   cover property (psel && penable && pslverr);
   cover property ($fell(gate_drive_out[0]) && $past(gate_cmd[0]));
   cover property (psel && penable && !pwrite && paddr == FAULT_OFS);
endmodule
`default_nettype wire

// >>> bench/uc_apb_model.sv
// apb master standing in for the controlling microcontroller
`timescale 1ns/100ps
`default_nettype none
module uc_apb_model (
   // clock
   input  wire logic        pclk,
   // request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   // answer
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic hung;
   initial begin
      hung = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // answer read in the cycle that closes on the ready edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
      int n;
      rd = 32'h0000_0000;
      er = 1'b1;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            rd = prdata;
            er = pslverr;
            break;
         end
      end
      if (n == 16)
         hung = 1'b1;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle lines must not keep looking valid
      paddr <= ~a;
      pwdata <= ~wd;
   endtask
endmodule
`default_nettype wire

// >>> bench/load_driver_fault_diagnostics_tb.sv
// self-checking bench for the load fault diagnostics block
`timescale 1ns/100ps
`default_nettype none
module load_driver_fault_diagnostics_tb
   import load_diag_pkg::*;
;
   logic        pclk, presetn, enable_in, psel, penable, pwrite;
   logic        pready, pslverr, pin_o, pin_oe, rerr;
   logic [7:0]  paddr, a;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  gate_cmd, pwm, retry, sb, sg, ol, gdo, g;
   int          bad_count, tests_run, seed, n;

   load_driver_fault_diagnostics #(.OL_ON_COUNT(4)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .enable_in(enable_in), .gate_cmd(gate_cmd), .pwm_period_pulse(pwm), .retry_expire(retry),
      .bat_short_raw(sb), .gnd_short_raw(sg), .open_load_raw(ol), .gate_drive_out(gdo),
      .fault_pin_o(pin_o), .fault_pin_oe(pin_oe));
   uc_apb_model uc (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] ad);
      uc.xfer(1'b0, ad, 32'h0000_0000, rdat, rerr);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      uc.xfer(1'b1, ad, d, rdat, rerr);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task automatic look;
      cyc(2);
      @(negedge pclk);
   endtask
   task automatic note(input string s);
      $display("%s done, errors %0d", s, bad_count);
   endtask
   function automatic int pre(input logic [1:0] s);
      return (s == 2'b00) ? 128 : (s == 2'b11) ? 256 : 192;
   endfunction
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      cyc(60000);
      bad_count++;
      report_and_stop;
   end

   initial begin
      bad_count = 0;
      tests_run = 0;
      seed = 84445;
      presetn = 1'b0;
      enable_in = 1'b1;
      {gate_cmd, pwm, retry, sb, sg, ol} = 24'h00_0000;
      @(negedge pclk);
      chk(32'({gdo, pin_o, pin_oe}), 32'h1);
      @(posedge pclk);
      presetn <= 1'b1;
      rd(FAULT_OFS);
      chk(rdat, 32'h0100_0000);
      rd(FAULT_OFS);
      chk(rdat, 32'h0000_0000);
      rd(CTRL_OFS);
      chk(rdat, 32'h0000_0000);
      rd(MASK_OFS);
      chk(rdat, 32'h0000_0000);
      look;
      chk(32'(pin_oe), 32'h0);
      note("reset");
      for (n = 0; n < 12; n++) begin
         a = (n == 0) ? 8'h40 : 8'($random(seed)) & 8'hFC;
         rd(a);
         chk(32'(rerr), 32'(a > 8'h0C));
      end
      repeat (64) begin
         @(posedge pclk);
         g = gate_cmd;
         gate_cmd <= 4'($random(seed));
         @(negedge pclk);
         chk(32'(gdo), 32'(g));
      end
      note("random");
      @(posedge pclk);
      gate_cmd <= 4'hF;
      enable_in <= 1'b0;
      for (n = 0; n < 4; n++) begin
         if (n == 2)
            enable_in <= 1'b1;
         rd(FAULT_OFS);
         chk(32'(rdat[FLD_ENABLE_LOW]), 32'(n < 3));
      end
      // each select: tested bit must not appear early, must appear in time
      for (n = 0; n < 4; n++) begin
         wr(CTRL_OFS, 32'h0000_00F0 | n);
         gate_cmd <= 4'h0;
         cyc(2);
         gate_cmd <= 4'h1;
         cyc(8 * pre(2'(n)) - 8);
         rd(FAULT_OFS);
         chk(rdat & 32'h3F, 32'h0);
         cyc(10 * pre(2'(n)) + 8);
         rd(FAULT_OFS);
         chk(rdat, 32'h0041_0402);
      end
      note("timebase");
      wr(CTRL_OFS, 32'h0000_00F0);
      sb <= 4'h1;
      cyc(512);
      sb <= 4'h0;
      sg <= 4'h1;
      ol <= 4'h1;
      cyc(1300);
      sb <= 4'h1;
      for (n = 0; n < 1536 && gdo[0] !== 1'b0; n++)
         @(negedge pclk);
      if (n == 1536) begin
         bad_count++;
         report_and_stop;
      end
      chk(32'(n >= 1024), 32'h1);
      cyc(40);
      wr(MASK_OFS, 32'h03FF_FFFF);
      look;
      chk(32'({gdo[0], pin_oe}), 32'h0);
      wr(MASK_OFS, 32'h0000_0000);
      look;
      chk(32'(pin_oe), 32'h1);
      rd(FAULT_OFS);
      chk(rdat, 32'h0041_0403);
      {sb, sg, ol} <= 12'h000;
      rd(FAULT_OFS);
      chk(rdat & 32'h3F, 32'h0);
      @(posedge pclk) retry <= 4'h1;
      @(posedge pclk) retry <= 4'h0;
      look;
      chk(32'(gdo[0]), 32'h1);
      note("short to battery");
      // channel 1 stays at zero current while off-state bits are judged
      @(posedge pclk);
      gate_cmd <= 4'h1;
      ol <= 4'h2;
      rd(FAULT_OFS);
      cyc(1300);
      rd(FAULT_OFS);
      chk(rdat & 32'h0FC0, 32'h0600);
      sg <= 4'h2;
      cyc(1300);
      rd(FAULT_OFS);
      cyc(1300);
      rd(FAULT_OFS);
      chk(rdat & 32'h0FC0, 32'h0500);
      {sg, ol} <= 8'h00;
      note("off state");
      wr(CTRL_OFS, 32'h0000_00B0);
      gate_cmd <= 4'hD;
      rd(FAULT_OFS);
      for (n = 1; n <= 8; n++) begin
         @(posedge pclk) pwm <= 4'hF;
         @(posedge pclk) pwm <= 4'h0;
         if (n % 4 == 0) begin
            rd(FAULT_OFS);
            chk(rdat & 32'h0082_0000, 32'h0002_0000);
         end
      end
      note("on-state open load");
      @(posedge pclk);
      presetn <= 1'b0;
      look;
      chk(32'(gdo), 32'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      rd(FAULT_OFS);
      chk(rdat, 32'h0100_0000);
      chk(32'(uc.hung), 32'h0);
      note("second reset");
      report_and_stop;
   end
endmodule

bind load_driver_fault_diagnostics diag_assertions sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enable_in(enable_in),
   .gate_cmd(gate_cmd), .retry_expire(retry_expire), .gate_drive_out(gate_drive_out));
`default_nettype wire
